// ---- design/plm_pkg.sv ----
package plm_pkg;
	// Mode codes as set by the configuration
	localparam logic [7:0] MODE_OFF = 8'h00;
	localparam logic [7:0] MODE_AND = 8'h01;
	localparam logic [7:0] MODE_OR = 8'h02;
	localparam logic [7:0] MODE_XOR = 8'h03;
	localparam logic [7:0] MODE_LATCH = 8'h0A;
	localparam logic [7:0] MODE_TOGGLE = 8'h14;
	localparam logic [7:0] MODE_DFF = 8'h1E;
	localparam int NUM_MODULES = 4;
	localparam int SEL_W = 4;
	localparam int EXT_W = 8;
	// Processing cycle
	localparam real CYCLE_MS = 16.0;
	localparam real CLK_HZ = 20.0e6;
	localparam int CYCLE_CLKS = int'(CYCLE_MS * 1.0e-3 * CLK_HZ);
	localparam logic [3:0] RST_OUT = 4'h0;
endpackage

// ---- design/plm_logic_modules.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Latch mode: first high, second low drives output high.
// - Latch mode: both inputs low holds previous output.
// - Latch mode: second high, first low drives output low.
// - Latch mode: both high drives output low; clear dominates.
// - Toggle mode: output inverts on each rising edge of first input.
// - Toggle mode: steady or falling first input keeps output.
// - Toggle mode: second input ignored entirely.
// - Data mode: clock (second) low holds output regardless of data.
// - Data mode: rising second input copies first input to output.
// - Data mode: falling second input leaves output unchanged.
// - Mode zero holds output low.
// - Modes one to three give AND, OR and XOR.
// - Modules evaluated in ascending order each 16 ms cycle.
// - Two selectable inputs per module; outputs usable as sources.
module plm_logic_modules #(
	parameter int CYCLE_LEN = plm_pkg::CYCLE_CLKS
)(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// External digital inputs
	input wire logic [7:0] ext_in_i,
	// Per-module configuration, four modules packed
	input wire logic [31:0] mode_i,
	input wire logic [15:0] first_logic_input_sel_i,
	input wire logic [15:0] second_logic_input_sel_i,
	// Results
	output logic [3:0] mod_out_o,
	output logic cycle_done_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_EVAL} plm_state_e;
	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] sync3;
		logic [7:0] ext_val;
		logic [22:0] tick;
		plm_state_e state;
		logic [1:0] idx;
		logic [3:0] q;
		logic [3:0] prev1;
		logic [3:0] prev2;
		logic done;
	} plm_state_s;

	plm_state_s st_reg;
	plm_state_s st_next;

	// Source 0..7 external, 8..11 module outputs, others low
	function automatic logic plm_pick(input logic [3:0] sel, input logic [7:0] ext,
		input logic [3:0] q);
		logic v;
		v = 1'b0;
		if (sel < 4'h8)
			v = ext[sel[2:0]];
		else if (sel < 4'hC)
			v = q[sel[1:0]];
		return v;
	endfunction

	logic a;
	logic b;
	logic pa;
	logic pb;
	logic qc;
	logic qn;
	logic [7:0] md;

	always_comb
	begin
		st_next = st_reg;
		st_next.sync1 = ext_in_i;
		st_next.sync2 = st_reg.sync1;
		st_next.sync3 = st_reg.sync2;
		// Accept a change once second and third stages agree
		if (st_reg.sync2 == st_reg.sync3)
			st_next.ext_val = st_reg.sync3;
		st_next.done = 1'b0;
		md = mode_i[st_reg.idx*8 +: 8];
		a = plm_pick(first_logic_input_sel_i[st_reg.idx*4 +: 4], st_reg.ext_val, st_reg.q);
		b = plm_pick(second_logic_input_sel_i[st_reg.idx*4 +: 4], st_reg.ext_val, st_reg.q);
		pa = st_reg.prev1[st_reg.idx];
		pb = st_reg.prev2[st_reg.idx];
		qc = st_reg.q[st_reg.idx];
		qn = qc;
		case (md)
			plm_pkg::MODE_OFF: qn = 1'b0;
			plm_pkg::MODE_AND: qn = a & b;
			plm_pkg::MODE_OR: qn = a | b;
			plm_pkg::MODE_XOR: qn = a ^ b;
			plm_pkg::MODE_LATCH: qn = ~b & (a | qc);
			plm_pkg::MODE_TOGGLE: qn = qc ^ (a & ~pa);
			plm_pkg::MODE_DFF: qn = (b & ~pb) ? a : qc;
			default: qn = 1'b0;
		endcase
		case (st_reg.state)
			ST_IDLE:
			begin
				if (st_reg.tick >= 23'(CYCLE_LEN - 1))
				begin
					st_next.tick = '0;
					st_next.idx = 2'h0;
					st_next.state = ST_EVAL;
				end
				else
					st_next.tick = st_reg.tick + 23'h1;
			end
			ST_EVAL:
			begin
				// One module per clock, ascending, results visible to later ones
				st_next.q[st_reg.idx] = qn;
				st_next.prev1[st_reg.idx] = a;
				st_next.prev2[st_reg.idx] = b;
				st_next.tick = st_reg.tick + 23'h1;
				st_next.idx = st_reg.idx + 2'h1;
				if (st_reg.idx == 2'h3)
				begin
					st_next.state = ST_IDLE;
					st_next.done = 1'b1;
				end
			end
			default: st_next.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_reg <= '0;
			st_reg.state <= ST_IDLE;
		end
		else
			st_reg <= st_next;
	end

	assign mod_out_o = st_reg.q;
	assign cycle_done_o = st_reg.done;

	a_off_low: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_OFF)
		|=> !st_reg.q[$past(st_reg.idx)])
		else $error("off mode output not low");
	a_and_result: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_AND)
		|=> st_reg.q[$past(st_reg.idx)] == $past(a & b))
		else $error("and result wrong");
	a_or_result: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_OR)
		|=> st_reg.q[$past(st_reg.idx)] == $past(a | b))
		else $error("or result wrong");
	a_latch_clear: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_LATCH && b)
		|=> !st_reg.q[$past(st_reg.idx)])
		else $error("latch clear not dominant");
	a_latch_reset: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_LATCH && !a && b)
		|=> !st_reg.q[$past(st_reg.idx)])
		else $error("latch reset failed");
	a_latch_set: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_LATCH && a && !b)
		|=> st_reg.q[$past(st_reg.idx)])
		else $error("latch set failed");
	a_latch_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_LATCH && !a && !b)
		|=> st_reg.q == $past(st_reg.q))
		else $error("latch hold failed");
	a_toggle_edge: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_TOGGLE && a && !pa)
		|=> st_reg.q[$past(st_reg.idx)] != $past(qc))
		else $error("toggle missed edge");
	a_toggle_keep: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_TOGGLE && !(a && !pa))
		|=> st_reg.q == $past(st_reg.q))
		else $error("toggle changed without edge");
	a_dff_clock_low: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_DFF && !b)
		|=> st_reg.q == $past(st_reg.q))
		else $error("data output changed with clock low");
	a_dff_capture: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_DFF && b && !pb)
		|=> st_reg.q[$past(st_reg.idx)] == $past(a))
		else $error("data capture wrong");
	a_dff_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_DFF && !(b && !pb))
		|=> st_reg.q == $past(st_reg.q))
		else $error("data output changed without edge");
	a_xor_result: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && md == plm_pkg::MODE_XOR)
		|=> st_reg.q[$past(st_reg.idx)] == $past(a ^ b))
		else $error("xor result wrong");
	a_eval_order: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && st_reg.idx == 2'h0) |=> st_reg.idx == 2'h1
		##1 st_reg.idx == 2'h2 ##1 st_reg.idx == 2'h3 ##1 st_reg.done)
		else $error("evaluation order broken");
	a_cycle_start: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_IDLE && st_reg.tick >= 23'(CYCLE_LEN - 1))
		|=> (st_reg.state == ST_EVAL && st_reg.idx == 2'h0))
		else $error("cycle did not start");
	a_idle_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_IDLE)
		|=> st_reg.q == $past(st_reg.q))
		else $error("outputs changed between evaluations");
	a_done_pulse: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		st_reg.done
		|=> !st_reg.done)
		else $error("cycle done longer than one clock");
	a_pick_module: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && first_logic_input_sel_i[st_reg.idx*4+2 +: 2] == 2'h2)
		|-> a == st_reg.q[first_logic_input_sel_i[st_reg.idx*4 +: 2]])
		else $error("module output source wrong");
	a_pick_low: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL && second_logic_input_sel_i[st_reg.idx*4+2 +: 2] == 2'h3)
		|-> !b)
		else $error("unused source not low");
	a_prev_sample: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(st_reg.state == ST_EVAL) |=> (st_reg.prev1[$past(st_reg.idx)] == $past(a)
		&& st_reg.prev2[$past(st_reg.idx)] == $past(b)))
		else $error("previous samples not stored");
	a_reset_clear: assert property (@(posedge ref_clk_i)
		(!nrst_i ##1 !nrst_i) |-> (st_reg.q == plm_pkg::RST_OUT && st_reg.prev1 == 4'h0
		&& st_reg.prev2 == 4'h0 && !st_reg.done))
		else $error("reset did not clear state");
endmodule

// ---- tb/plm_input_src.sv ----
`timescale 1ns/1ns
module plm_input_src (
	// Clock
	input wire logic ref_clk_i,
	// Levels requested by the bench
	input wire logic [7:0] lvl_i,
	// Pins towards the block
	output logic [7:0] ext_in_o
);
	initial ext_in_o = 8'h00;
	// Contacts move after the edge, unrelated to evaluation
	always @(posedge ref_clk_i)
		ext_in_o <= lvl_i;
endmodule

// ---- tb/programmable_logic_module_test.sv ----
`timescale 1ns/1ns
module programmable_logic_module_test;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] lvl = 8'h00;
	logic [7:0] ext_in;
	logic [31:0] mode = 32'h0;
	logic [15:0] s1 = 16'h0;
	logic [15:0] s2 = 16'h0;
	logic [3:0] mod_out;
	logic done;
	logic [3:0] q_exp [$];
	logic [3:0] q, p1, p2;
	logic [7:0] codes [8];
	logic [31:0] rnd = 32'h49FE;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	int gap = -1;
	localparam int CYC_LEN = 16;
	always #25 ref_clk_i = ~ref_clk_i;
	plm_input_src src_model (.ref_clk_i(ref_clk_i), .lvl_i(lvl), .ext_in_o(ext_in));
	plm_logic_modules #(.CYCLE_LEN(CYC_LEN)) DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.ext_in_i(ext_in), .mode_i(mode), .first_logic_input_sel_i(s1),
		.second_logic_input_sel_i(s2), .mod_out_o(mod_out), .cycle_done_o(done));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic src(input logic [3:0] s);
		return s < 4'h8 ? lvl[s[2:0]] : (s < 4'hC ? q[s[1:0]] : 1'b0);
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Reference of one processing cycle, modules in ascending order
	task automatic predict();
		logic a, b, n;
		for (int k = 0; k < 4; k++)
		begin
			a = src(s1[4*k+:4]);
			b = src(s2[4*k+:4]);
			case (mode[8*k+:8])
				plm_pkg::MODE_AND: n = a & b;
				plm_pkg::MODE_OR: n = a | b;
				plm_pkg::MODE_XOR: n = a ^ b;
				plm_pkg::MODE_LATCH: n = !b && (a || q[k]);
				plm_pkg::MODE_TOGGLE: n = q[k] ^ (a & !p1[k]);
				plm_pkg::MODE_DFF: n = (b & !p2[k]) ? a : q[k];
				default: n = 1'b0;
			endcase
			q[k] = n;
			p1[k] = a;
			p2[k] = b;
		end
		q_exp.push_back(q);
	endtask
	initial
	begin
		q = 4'h0;
		p1 = 4'h0;
		p2 = 4'h0;
		codes = '{plm_pkg::MODE_OFF, plm_pkg::MODE_AND, plm_pkg::MODE_OR, plm_pkg::MODE_XOR,
			plm_pkg::MODE_LATCH, plm_pkg::MODE_TOGGLE, plm_pkg::MODE_DFF, 8'h07};
		repeat (20) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		check("reset outputs", mod_out, 4'h0);
		check("reset done", done, 1'b0);
		predict();
		repeat (200)
		begin
			@(posedge ref_clk_i);
			while (done !== 1'b1)
				@(posedge ref_clk_i);
			rnd = lfsr(rnd);
			lvl <= rnd[7:0];
			s1 <= rnd[23:8];
			rnd = lfsr(rnd);
			s2 <= rnd[15:0];
			mode <= {codes[rnd[18:16]], codes[rnd[21:19]], codes[rnd[24:22]], codes[rnd[27:25]]};
			#1 predict();
		end
		give_verdict();
	end
	always @(negedge ref_clk_i)
	begin
		if (gap >= 0)
			gap++;
		if (done === 1'b1)
		begin
			check("module outputs", mod_out, q_exp.pop_front());
			if (gap > 0)
				check("cycle period", gap, CYC_LEN);
			gap = 0;
		end
	end
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			error_cnt++;
			give_verdict();
		end
	end
endmodule
